// File: common/rcc_pkg.sv
package rcc_pkg;
    localparam int          ADDR_W           = 5;
    localparam int          DATA_W           = 8;
    localparam int          IR_W             = ADDR_W;
    // serial register addresses
    localparam logic [4:0]  ADDR_TRIM_SIG    = 5'h13;
    localparam logic [4:0]  ADDR_CLK_CTRL    = 5'h16;
    localparam logic [4:0]  ADDR_FUNC_EN     = 5'h19;
    localparam logic [4:0]  ADDR_SHAPE_TBL   = 5'h1C;
    // reset values
    localparam logic [7:0]  TRIM_RESET       = 8'h80;
    localparam logic [7:0]  CLK_CTRL_RESET   = 8'h00;
    localparam logic [7:0]  FUNC_EN_RESET    = 8'h00;
    // arbitrary signature value
    localparam logic [7:0]  CHIP_SIG_DEFAULT = 8'h5C;
    // field positions
    localparam int          CTRL_RDY_BIT     = 2;
    localparam int          EN_GRST_BIT      = 6;
    localparam int          EN_CLK_BIT       = 4;
    localparam logic [7:0]  TRIM_MASK        = 8'h7F;
    localparam logic [7:0]  CTRL_MASK        = 8'h04;
    localparam logic [7:0]  EN_MASK          = 8'h50;
    // pulse-shape table
    localparam int          SHAPE_N          = 13;
    localparam int          SHAPE_PTR_W      = 4;
    localparam logic [3:0]  SHAPE_LAST       = 4'hC;
    localparam logic [3:0]  SHAPE_FIRST      = 4'h0;
    // reset-done delay in system clocks
    localparam logic [2:0]  RST_DONE_CYC     = 3'h4;
    // low-power clock divider half period (sim-shortened default)
    localparam int          LPO_HALF_W       = 12;
    localparam logic [11:0] LPO_HALF_DEF     = 12'h7EF;
    // codec clock toggle divider half period
    localparam logic [1:0]  PCM_HALF         = 2'h2;
    typedef enum logic [3:0] {
        RCC_TLR, RCC_IDLE, RCC_SEL_DR, RCC_CAP_DR, RCC_SH_DR, RCC_EX1_DR, RCC_PA_DR,
        RCC_EX2_DR, RCC_UPD_DR, RCC_SEL_IR, RCC_CAP_IR, RCC_SH_IR, RCC_EX1_IR,
        RCC_PA_IR, RCC_EX2_IR, RCC_UPD_IR
    } rcc_tap_t;
    typedef enum logic [2:0] {
        RCC_TX_OFF, RCC_TX_SETTLE, RCC_TX_PRESET, RCC_TX_RESETTLE, RCC_TX_OPEN
    } rcc_tx_t;
endpackage

// File: src/rcc_regs.sv
`timescale 1ns/100ps
// Functional notes
// - trim bits b6..b0 add binary-weighted load, 6 pF down to 0.09375 pF
// - read at address 19 returns fixed 8-bit chip signature
// - clock control b2 is host-ready, deciding if clock request applies
// - writing 1 to enable b6 clears shape table pointer
// - enable b4 switches the 2.048 MHz codec clock on or off
// - table at address 28 holds 13 eight-bit shape entries
// - each table write with enable b6 clear stores at pointer then advances pointer
// - power-on reset returns all registers to defaults
// - external reset gives same state as power-on reset
// - after reset oscillator runs and system clock output enabled
// - host-ready 0: ignore clock request, keep system clock on
// - host-ready 1: clock request gates system clock output
// - clock request gates output only, never stops oscillator
// - low-power clock and reset-done follow power-on and external reset only
// - reset-done goes active 4 system clocks after external reset
// - transmit: settle, power amp on, preset mean, resettle, open loop
// - transmit bitstream is shaped and drives the modulator level
// - synthesizer loop off throughout received packet demodulation
// - received signal sliced against threshold and driven out as bits
// - serial test-access link, 5-bit address, 8-bit data scans
// - trim resets to 0x80; control, enable and table reset to zero
module rcc_regs
    import rcc_pkg::*;
#(
    parameter logic [11:0] LPO_HALF = LPO_HALF_DEF
)(
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  external_reset_input,
    // serial test-access link
    input  wire logic                  link_clk,
    input  wire logic                  link_mode,
    input  wire logic                  link_din,
    output logic                       link_dout,
    // system clock gating
    input  wire logic                  system_clock_request,
    output logic                       system_clock_output,
    output logic                       osc_enable,
    output logic                       low_power_clock,
    output logic                       reset_done,
    output logic                       codec_clock,
    // oscillator load trim
    output logic [6:0]                 crystal_load_trim,
    // radio sequencing
    input  wire logic                  synth_on,
    input  wire logic                  pa_on,
    input  wire logic                  synth_settled,
    input  wire logic                  tx_bit,
    input  wire logic [DATA_W-1:0]     rx_sample,
    input  wire logic [DATA_W-1:0]     slicer_level,
    output logic                       pa_enable,
    output logic                       synth_loop_closed,
    output logic [DATA_W-1:0]          mod_level,
    output logic                       rx_bit
);
    import rcc_pkg::*;

    //------------------------------------------------------------
    // input synchronisers
    //------------------------------------------------------------
    logic [1:0] lclk_s_r, lmode_s_r, ldin_s_r, req_s_r, xrst_s_r, son_s_r, pon_s_r, sst_s_r, txb_s_r;
    logic       lclk_d_r;
    always_ff @(posedge clock)
    begin
        lclk_s_r  <= {lclk_s_r[0], link_clk};
        lmode_s_r <= {lmode_s_r[0], link_mode};
        ldin_s_r  <= {ldin_s_r[0], link_din};
        req_s_r   <= {req_s_r[0], system_clock_request};
        xrst_s_r  <= {xrst_s_r[0], external_reset_input};
        son_s_r   <= {son_s_r[0], synth_on};
        pon_s_r   <= {pon_s_r[0], pa_on};
        sst_s_r   <= {sst_s_r[0], synth_settled};
        txb_s_r   <= {txb_s_r[0], tx_bit};
        lclk_d_r  <= lclk_s_r[1];
    end

    logic lclk_rise, lclk_fall, dev_rst, pin_rst;
    assign lclk_rise = lclk_s_r[1] & ~lclk_d_r;
    assign lclk_fall = ~lclk_s_r[1] & lclk_d_r;
    // external reset is active low on the pin
    // reset-done and low-power clock see only this, never register bits
    assign pin_rst   = rst | ~xrst_s_r[1];
    assign dev_rst   = pin_rst;

    //------------------------------------------------------------
    // tap controller
    //------------------------------------------------------------
    rcc_tap_t tap_r, tap_nxt;
    always_comb
    begin
        unique case (tap_r)
            RCC_TLR:    tap_nxt = lmode_s_r[1] ? RCC_TLR    : RCC_IDLE;
            RCC_IDLE:   tap_nxt = lmode_s_r[1] ? RCC_SEL_DR : RCC_IDLE;
            RCC_SEL_DR: tap_nxt = lmode_s_r[1] ? RCC_SEL_IR : RCC_CAP_DR;
            RCC_CAP_DR: tap_nxt = lmode_s_r[1] ? RCC_EX1_DR : RCC_SH_DR;
            RCC_SH_DR:  tap_nxt = lmode_s_r[1] ? RCC_EX1_DR : RCC_SH_DR;
            RCC_EX1_DR: tap_nxt = lmode_s_r[1] ? RCC_UPD_DR : RCC_PA_DR;
            RCC_PA_DR:  tap_nxt = lmode_s_r[1] ? RCC_EX2_DR : RCC_PA_DR;
            RCC_EX2_DR: tap_nxt = lmode_s_r[1] ? RCC_UPD_DR : RCC_SH_DR;
            RCC_UPD_DR: tap_nxt = lmode_s_r[1] ? RCC_SEL_DR : RCC_IDLE;
            RCC_SEL_IR: tap_nxt = lmode_s_r[1] ? RCC_TLR    : RCC_CAP_IR;
            RCC_CAP_IR: tap_nxt = lmode_s_r[1] ? RCC_EX1_IR : RCC_SH_IR;
            RCC_SH_IR:  tap_nxt = lmode_s_r[1] ? RCC_EX1_IR : RCC_SH_IR;
            RCC_EX1_IR: tap_nxt = lmode_s_r[1] ? RCC_UPD_IR : RCC_PA_IR;
            RCC_PA_IR:  tap_nxt = lmode_s_r[1] ? RCC_EX2_IR : RCC_PA_IR;
            RCC_EX2_IR: tap_nxt = lmode_s_r[1] ? RCC_UPD_IR : RCC_SH_IR;
            RCC_UPD_IR: tap_nxt = lmode_s_r[1] ? RCC_SEL_DR : RCC_IDLE;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (dev_rst)
            tap_r <= RCC_TLR;
        else if (lclk_rise)
            tap_r <= tap_nxt;
    end

    //------------------------------------------------------------
    // shift registers and register file
    //------------------------------------------------------------
    logic [IR_W-1:0]   ir_sh_r, ir_r;
    logic [DATA_W-1:0] dr_sh_r;
    logic [DATA_W-1:0] trim_r, ctrl_r, en_r;
    logic [DATA_W-1:0] shape_mem [SHAPE_N];
    logic [SHAPE_PTR_W-1:0] ptr_r;
    logic              dr_upd;

    function automatic logic [DATA_W-1:0] rd_mux(input logic [IR_W-1:0] a);
        unique case (a)
            ADDR_TRIM_SIG: rd_mux = CHIP_SIG_DEFAULT;
            ADDR_CLK_CTRL: rd_mux = ctrl_r;
            ADDR_FUNC_EN:  rd_mux = en_r;
            default:       rd_mux = '0;
        endcase
    endfunction

    assign dr_upd = lclk_rise & (tap_r == RCC_UPD_DR);

    // write strobe for one register address
    function automatic logic wr_hit(input logic [IR_W-1:0] a);
        wr_hit = dr_upd && (ir_r == a);
    endfunction

    always_ff @(posedge clock)
    begin
        if (dev_rst)
        begin
            ir_sh_r <= '0;
            ir_r    <= '0;
        end
        else if (lclk_rise)
        begin
            if (tap_r == RCC_CAP_IR)
                ir_sh_r <= ir_r;
            else if (tap_r == RCC_SH_IR)
                ir_sh_r <= {ldin_s_r[1], ir_sh_r[IR_W-1:1]};
            else if (tap_r == RCC_UPD_IR)
                ir_r <= ir_sh_r;
        end
    end

    always_ff @(posedge clock)
    begin
        if (dev_rst)
            dr_sh_r <= '0;
        else if (lclk_rise)
        begin
            if (tap_r == RCC_CAP_DR)
                dr_sh_r <= rd_mux(ir_r);
            else if (tap_r == RCC_SH_DR)
                dr_sh_r <= {ldin_s_r[1], dr_sh_r[DATA_W-1:1]};
        end
    end

    // output changes on the falling link edge
    always_ff @(posedge clock)
    begin
        if (dev_rst)
            link_dout <= 1'b0;
        else if (lclk_fall)
            link_dout <= (tap_r == RCC_SH_IR) ? ir_sh_r[0] : dr_sh_r[0];
    end

    always_ff @(posedge clock)
    begin
        if (dev_rst)
        begin
            trim_r <= TRIM_RESET;
            ctrl_r <= CLK_CTRL_RESET;
            en_r   <= FUNC_EN_RESET;
        end
        else
        begin
            if (wr_hit(ADDR_TRIM_SIG))
                trim_r <= dr_sh_r & TRIM_MASK;
            if (wr_hit(ADDR_CLK_CTRL))
                ctrl_r <= dr_sh_r & CTRL_MASK;
            if (wr_hit(ADDR_FUNC_EN))
                en_r   <= dr_sh_r & EN_MASK;
        end
    end

    // pointer held at first entry while clear bit stays set
    always_ff @(posedge clock)
    begin
        if (dev_rst || en_r[EN_GRST_BIT])
            ptr_r <= SHAPE_FIRST;
        else if (wr_hit(ADDR_SHAPE_TBL))
            ptr_r <= (ptr_r == SHAPE_LAST) ? SHAPE_FIRST : ptr_r + 1'b1;
    end

    always_ff @(posedge clock)
    begin
        if (dev_rst)
        begin
            for (int i = 0; i < SHAPE_N; i++)
                shape_mem[i] <= '0;
        end
        else if (wr_hit(ADDR_SHAPE_TBL) && !en_r[EN_GRST_BIT])
            shape_mem[ptr_r] <= dr_sh_r;
    end

    assign crystal_load_trim = trim_r[6:0];

    //------------------------------------------------------------
    // clock gating and reset sequencing
    //------------------------------------------------------------
    logic [2:0] rd_cnt_r;
    always_ff @(posedge clock)
    begin
        if (pin_rst)
            rd_cnt_r <= '0;
        else if (rd_cnt_r != RST_DONE_CYC)
            rd_cnt_r <= rd_cnt_r + 1'b1;
    end
    assign reset_done = (rd_cnt_r == RST_DONE_CYC);

    // oscillator never gated by request
    assign osc_enable = 1'b1;
    always_ff @(posedge clock)
    begin
        if (dev_rst)
            system_clock_output <= 1'b1;
        else
            system_clock_output <= ctrl_r[CTRL_RDY_BIT] ? req_s_r[1] : 1'b1;
    end

    logic [LPO_HALF_W-1:0] lpo_cnt_r;
    always_ff @(posedge clock)
    begin
        if (pin_rst)
        begin
            lpo_cnt_r       <= '0;
            low_power_clock <= 1'b0;
        end
        else if (lpo_cnt_r == LPO_HALF)
        begin
            lpo_cnt_r       <= '0;
            low_power_clock <= ~low_power_clock;
        end
        else
            lpo_cnt_r <= lpo_cnt_r + 1'b1;
    end

    logic [1:0] pcm_cnt_r;
    always_ff @(posedge clock)
    begin
        if (dev_rst || !en_r[EN_CLK_BIT])
        begin
            pcm_cnt_r   <= '0;
            codec_clock <= 1'b0;
        end
        else if (pcm_cnt_r == PCM_HALF)
        begin
            pcm_cnt_r   <= '0;
            codec_clock <= ~codec_clock;
        end
        else
            pcm_cnt_r <= pcm_cnt_r + 1'b1;
    end

    //------------------------------------------------------------
    // transmit and receive sequencing
    //------------------------------------------------------------
    rcc_tx_t tx_r;
    always_ff @(posedge clock)
    begin
        if (dev_rst || !pon_s_r[1])
            tx_r <= RCC_TX_OFF;
        else
        begin
            unique case (tx_r)
                RCC_TX_OFF:      tx_r <= RCC_TX_SETTLE;
                RCC_TX_SETTLE:   if (sst_s_r[1]) tx_r <= RCC_TX_PRESET;
                RCC_TX_PRESET:   tx_r <= RCC_TX_RESETTLE;
                RCC_TX_RESETTLE: if (sst_s_r[1]) tx_r <= RCC_TX_OPEN;
                RCC_TX_OPEN:     tx_r <= RCC_TX_OPEN;
            endcase
        end
    end

    // shaping: walk the table toward the bit's end
    logic [SHAPE_PTR_W-1:0] mod_idx_r;
    always_ff @(posedge clock)
    begin
        if (dev_rst || tx_r != RCC_TX_OPEN)
            mod_idx_r <= SHAPE_LAST >> 1;
        else if (txb_s_r[1] && mod_idx_r != SHAPE_LAST)
            mod_idx_r <= mod_idx_r + 1'b1;
        else if (!txb_s_r[1] && mod_idx_r != SHAPE_FIRST)
            mod_idx_r <= mod_idx_r - 1'b1;
    end

    always_ff @(posedge clock)
    begin
        if (dev_rst)
        begin
            pa_enable         <= 1'b0;
            synth_loop_closed <= 1'b0;
            mod_level         <= '0;
            rx_bit            <= 1'b0;
        end
        else
        begin
            pa_enable         <= tx_r inside {RCC_TX_PRESET, RCC_TX_RESETTLE, RCC_TX_OPEN};
            // loop open once transmit reaches RCC_TX_OPEN, and while receiving
            synth_loop_closed <= son_s_r[1] && tx_r != RCC_TX_OPEN;
            mod_level         <= shape_mem[mod_idx_r];
            rx_bit            <= (!son_s_r[1] && rx_sample > slicer_level) ? 1'b1 : 1'b0;
        end
    end
endmodule

// File: tb/rcc_props.sv
`timescale 1ns/100ps
// ----------------------------------------
// port checks for the register bank
// ----------------------------------------
module rcc_props
    import rcc_pkg::*;
#(
    parameter logic [11:0] LPO_HALF = LPO_HALF_DEF
)(
    // clock and reset
    input wire logic              clock,
    input wire logic              rst,
    input wire logic              external_reset_input,
    // clocks out
    input wire logic              system_clock_request,
    input wire logic              system_clock_output,
    input wire logic              low_power_clock,
    input wire logic              reset_done,
    input wire logic              codec_clock,
    // radio
    input wire logic              synth_on,
    input wire logic              pa_on,
    input wire logic              pa_enable,
    input wire logic              synth_loop_closed,
    input wire logic [DATA_W-1:0] rx_sample,
    input wire logic [DATA_W-1:0] slicer_level,
    input wire logic              rx_bit
);
    logic [11:0] lpo_cnt_r;
    logic        lpo_prev_r;
    logic        lpo_armed_r;
    // cycles since the last low-power clock change
    always_ff @(posedge clock)
    begin
        lpo_prev_r <= low_power_clock;
        if (rst || !reset_done || low_power_clock != lpo_prev_r)
            lpo_cnt_r <= 12'h000;
        else
            lpo_cnt_r <= lpo_cnt_r + 12'h001;
    end
    always_ff @(posedge clock)
    begin
        if (rst || !reset_done)
            lpo_armed_r <= 1'b0;
        else if (low_power_clock != lpo_prev_r)
            lpo_armed_r <= 1'b1;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_sclk_req_on:
        assert property (system_clock_request[*5] |-> system_clock_output) else $error("system clock off");
    a_sclk_fall_cause:
        assert property ($fell(system_clock_output) |-> !$past(system_clock_request, 3))
        else $error("system clock gated without request low");
    a_rdone_lag:
        assert property ($rose(reset_done) |-> $past(external_reset_input, 4) && !$past(rst, 4))
        else $error("reset done too early");
    a_codec_low_phase:
        assert property ($rose(codec_clock) |-> !$past(codec_clock, 2) && !$past(codec_clock, 3))
        else $error("codec clock low phase short");
    a_lpo_half_period:
        assert property (disable iff (rst || !reset_done)
            low_power_clock != lpo_prev_r && lpo_armed_r |-> lpo_cnt_r == LPO_HALF)
        else $error("low power clock period wrong");
    a_rx_loop_open:
        assert property ((!synth_on && !pa_on)[*5] |-> !synth_loop_closed) else $error("loop closed in receive");
    a_rx_slice_bit:
        assert property ((!synth_on && !pa_on)[*5] |=> rx_bit == ($past(rx_sample) > $past(slicer_level)))
        else $error("slicer bit wrong");
    a_loop_open_late:
        assert property ($fell(synth_loop_closed) && pa_enable |-> $past(pa_enable))
        else $error("loop opened with amplifier start");
endmodule

bind rcc_regs rcc_props #(.LPO_HALF(LPO_HALF)) rcc_props_inst (.clock, .rst, .external_reset_input,
    .system_clock_request, .system_clock_output, .low_power_clock, .reset_done, .codec_clock, .synth_on,
    .pa_on, .pa_enable, .synth_loop_closed, .rx_sample, .slicer_level, .rx_bit);

// File: tb/rcc_link_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// baseband side of the serial link
// ----------------------------------------
module rcc_link_model
(
    // clock
    input wire logic clock,
    // serial link
    output logic     link_clk,
    output logic     link_mode,
    output logic     link_din,
    input wire logic link_dout
);
    logic last_r;
    initial
    begin
        link_clk = 1'b0;
        link_mode = 1'b1;
        link_din = 1'b0;
        last_r = 1'b0;
    end
    // one link cycle, 4 clocks a phase, clock idles low
    task automatic step(input logic m, input logic d, output logic q);
        link_mode <= m;
        link_din <= d;
        last_r = d;
        repeat (4) @(posedge clock);
        link_clk <= 1'b1;
        repeat (2) @(posedge clock);
        q = link_dout;
        repeat (2) @(posedge clock);
        link_clk <= 1'b0;
    endtask
    // address scan then 8-bit data scan, lsb first
    task automatic frame(input logic [4:0] a, input logic [7:0] wd, output logic [7:0] rd);
        logic q;
        step(1'b0, ~last_r, q);
        step(1'b1, ~last_r, q);
        step(1'b1, ~last_r, q);
        step(1'b0, ~last_r, q);
        step(1'b0, ~last_r, q);
        for (int i = 0; i < 5; i++)
            step(i == 4, a[i], q);
        step(1'b1, ~last_r, q);
        step(1'b1, ~last_r, q);
        step(1'b0, ~last_r, q);
        step(1'b0, ~last_r, q);
        for (int i = 0; i < 8; i++)
        begin
            step(i == 7, wd[i], q);
            rd[i] = q;
        end
        step(1'b1, ~last_r, q);
        step(1'b0, ~last_r, q);
    endtask
endmodule

// File: tb/testbench.sv
`timescale 1ns/100ps
// ----------------------------------------
// register bank bench
// ----------------------------------------
module testbench;
    import rcc_pkg::*;
    logic       clock, rst, external_reset_input, link_clk, link_mode, link_din, link_dout;
    logic       system_clock_request, system_clock_output, osc_enable, low_power_clock, reset_done;
    logic       codec_clock, synth_on, pa_on, synth_settled, tx_bit, pa_enable, synth_loop_closed, rx_bit;
    logic [6:0] crystal_load_trim;
    logic [7:0] rx_sample, slicer_level, mod_level, rd;
    int         bad_count = 0;
    int         tests_run = 0;
    logic [7:0] shape [13] = '{8'h3B, 8'h3C, 8'h3E, 8'h42, 8'h4A, 8'h57, 8'h66, 8'h75, 8'h82, 8'h8A, 8'h8E,
                               8'h90, 8'h91};
    rcc_regs #(.LPO_HALF(12'h004)) rcc_regs_inst (.clock, .rst, .external_reset_input, .link_clk, .link_mode,
        .link_din, .link_dout, .system_clock_request, .system_clock_output, .osc_enable, .low_power_clock,
        .reset_done, .codec_clock, .crystal_load_trim, .synth_on, .pa_on, .synth_settled, .tx_bit, .rx_sample,
        .slicer_level, .pa_enable, .synth_loop_closed, .mod_level, .rx_bit);
    rcc_link_model rcc_link_model_inst (.clock, .link_clk, .link_mode, .link_din, .link_dout);
    always #50 clock = ~clock;
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic [4:0] a, input logic [7:0] wd);
        rcc_link_model_inst.frame(a, wd, rd);
        @(posedge clock);
    endtask
    task automatic wait_for(ref logic sig, input logic val, output int n);
        n = 0;
        while (sig !== val && n < 60)
        begin
            @(negedge clock);
            n++;
        end
        if (sig !== val)
        begin
            bad_count++;
            $display("ERROR wait expected %b seen %b", val, sig);
        end
    endtask
    task automatic t_defaults;
        xfer(ADDR_CLK_CTRL, 8'h00);
        check("ctrl", CLK_CTRL_RESET, rd);
        xfer(ADDR_FUNC_EN, 8'h00);
        check("enable", FUNC_EN_RESET, rd);
        check("trim", {1'b0, TRIM_RESET[6:0]}, {1'b0, crystal_load_trim});
        xfer(ADDR_TRIM_SIG, 8'hFF);
        check("signature", CHIP_SIG_DEFAULT, rd);
        check("trim", 8'h7F, {1'b0, crystal_load_trim});
        xfer(ADDR_TRIM_SIG, 8'h2A);
        check("signature", CHIP_SIG_DEFAULT, rd);
        check("trim", 8'h2A, {1'b0, crystal_load_trim});
        xfer(5'h1F, 8'h00);
        check("unmapped", 8'h00, rd);
    endtask
    task automatic t_clock_gate;
        system_clock_request <= 1'b0;
        repeat (6) @(posedge clock);
        check("sysclk", 8'h01, {7'h0, system_clock_output});
        xfer(ADDR_CLK_CTRL, 8'hFF);
        xfer(ADDR_CLK_CTRL, 8'h04);
        check("ctrl", CTRL_MASK, rd);
        check("sysclk", 8'h00, {7'h0, system_clock_output});
        check("osc", 8'h01, {7'h0, osc_enable});
        system_clock_request <= 1'b1;
        repeat (5) @(posedge clock);
        check("sysclk", 8'h01, {7'h0, system_clock_output});
    endtask
    task automatic count_codec(input logic [7:0] exp);
        logic [7:0] n;
        n = 8'h00;
        repeat (12)
        begin
            @(negedge clock);
            n += {7'h0, codec_clock};
        end
        check("codec highs", exp, n);
        @(posedge clock);
    endtask
    task automatic t_codec;
        xfer(ADDR_FUNC_EN, 8'h10);
        count_codec(8'h06);
        xfer(ADDR_FUNC_EN, 8'h00);
        check("enable", 8'h10, rd);
        count_codec(8'h00);
    endtask
    task automatic tx_check(input logic [7:0] exp);
        int n;
        pa_on <= 1'b1;
        synth_settled <= 1'b1;
        wait_for(pa_enable, 1'b1, n);
        check("mean preset", exp, mod_level);
        wait_for(synth_loop_closed, 1'b0, n);
        check("loop open", 8'h00, {7'h0, synth_loop_closed});
        @(posedge clock);
        tx_bit <= 1'b1;
        repeat (30) @(posedge clock);
        check("walk moved", 8'h01, {7'h0, mod_level !== exp});
        pa_on <= 1'b0;
        tx_bit <= 1'b0;
        synth_settled <= 1'b0;
        repeat (10) @(posedge clock);
    endtask
    task automatic t_table;
        xfer(ADDR_SHAPE_TBL, 8'h11);
        xfer(ADDR_FUNC_EN, 8'h40);
        xfer(ADDR_FUNC_EN, 8'h00);
        check("enable", 8'h40, rd);
        foreach (shape[i])
            xfer(ADDR_SHAPE_TBL, shape[i]);
        tx_check(shape[6]);
        repeat (7)
            xfer(ADDR_SHAPE_TBL, 8'hA5);
        tx_check(8'hA5);
    endtask
    task automatic t_rx;
        synth_on <= 1'b0;
        slicer_level <= 8'h80;
        rx_sample <= 8'h81;
        repeat (8) @(posedge clock);
        check("loop", 8'h00, {7'h0, synth_loop_closed});
        check("rx bit", 8'h01, {7'h0, rx_bit});
        rx_sample <= 8'h80;
        repeat (2) @(posedge clock);
        check("rx bit", 8'h00, {7'h0, rx_bit});
        synth_on <= 1'b1;
        repeat (8) @(posedge clock);
        check("loop", 8'h01, {7'h0, synth_loop_closed});
    endtask
    task automatic t_ext_reset;
        int n;
        system_clock_request <= 1'b0;
        external_reset_input <= 1'b0;
        repeat (6) @(posedge clock);
        check("done in reset", 8'h00, {7'h0, reset_done});
        check("lpo in reset", 8'h00, {7'h0, low_power_clock});
        external_reset_input <= 1'b1;
        wait_for(reset_done, 1'b1, n);
        check("done lag ok", 8'h01, {7'h0, n >= 5 && n <= 10});
        check("sysclk", 8'h01, {7'h0, system_clock_output});
        check("trim", 8'h00, {1'b0, crystal_load_trim});
        xfer(ADDR_CLK_CTRL, 8'h00);
        check("ctrl", CLK_CTRL_RESET, rd);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        clock = 1'b0;
        rst = 1'b1;
        external_reset_input = 1'b1;
        {system_clock_request, synth_on, pa_on, synth_settled, tx_bit} = 5'b11000;
        {rx_sample, slicer_level} = 16'h0000;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        t_defaults;
        t_clock_gate;
        t_codec;
        t_table;
        @(posedge clock);
        t_rx;
        t_ext_reset;
        final_report;
    end
    initial
    begin
        repeat (20000) @(posedge clock);
        bad_count++;
        $display("ERROR watchdog expected done seen timeout");
        final_report;
    end
endmodule
